// >>> rtl/dtc_pkg.sv
// constants for the dual timer/event counter block
package dtc_pkg;

    // ****************************************
    // bus geometry
    // ****************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int IDX_W = 6;

    // ****************************************
    // register indices; byte address is index times four
    // ****************************************
    localparam logic [IDX_W-1:0] IDX_COUNT0_HIGH_BYTE = 6'h0C;
    localparam logic [IDX_W-1:0] IDX_COUNT0_LOW_BYTE = 6'h0D;
    localparam logic [IDX_W-1:0] IDX_COUNT0_CONTROL = 6'h0E;
    localparam logic [IDX_W-1:0] IDX_COUNT1_HIGH_BYTE = 6'h0F;
    localparam logic [IDX_W-1:0] IDX_COUNT1_LOW_BYTE = 6'h10;
    localparam logic [IDX_W-1:0] IDX_COUNT1_CONTROL = 6'h11;
    localparam logic [IDX_W-1:0] IDX_OVERFLOW_STATUS = 6'h12;

    // ****************************************
    // control register fields
    // ****************************************
    localparam int CTL_EDGE_BIT = 3;
    localparam int CTL_RUN_BIT = 4;
    localparam int CTL_MODE_LO = 6;
    localparam int CTL_MODE_HI = 7;

    // overflow status register: flags bits 1:0 (write one clears), enables bits 3:2
    localparam int ST_FLAG_LO = 0;
    localparam int ST_EN_LO = 2;

    typedef enum logic [1:0] {
        DTC_MODE_UNUSED = 2'b00,
        DTC_MODE_EVENT = 2'b01,
        DTC_MODE_TIMER = 2'b10,
        DTC_MODE_PULSE = 2'b11
    } dtc_mode_e;

    // ****************************************
    // counting
    // ****************************************
    localparam int INSTR_CLK_DIV = 4;
    localparam int PRESCALE_W = $clog2(INSTR_CLK_DIV);
    localparam int REF_CLK_HZ = 32768;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : dtc_pkg

// >>> rtl/dtc_top.sv
// two 16-bit timer/event counters behind an AXI4-Lite register slave
// Notes on behaviour
// R1 - counter zero internal source: clock divided four
// R2 - counter one internal source: 32768Hz reference
// R3 - both counters sixteen-bit up counters, mode-selected clock
// R4 - low byte write fills holding buffer only
// R5 - high byte write loads preload with buffer
// R6 - high byte read latches low byte; read high first
// R7 - control bits 0-2 and 5 read zero
// R8 - control bit 4 runs or stops counter
// R9 - bits 7:6 select event, timer, pulse mode
// R10 - edge bit in event and timer modes: 0 rising, 1 falling edge
// R11 - event mode counts external pin edges
// R12 - pulse mode counts counter's internal source
// R13 - overflow reloads preload and sets flag together
// R14 - pulse: start on edge, stop returning, clear run
// R15 - one pulse measured; rerun needs run set again
// R16 - pulse start needs transition, not level
// R17 - overflow during pulse reloads, flags, keeps measuring
// R18 - event and timer modes never self-clear run
// R19 - overflow produces a wake-up pulse
// R20 - cleared enable blocks interrupt service request
// R21 - preload write while stopped also loads counter
// R22 - preload write while running touches preload only
// R23 - edge select sits at control bit 3
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module dtc_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [dtc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [dtc_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [dtc_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [dtc_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic counter_zero_input_pin,
    input wire logic counter_one_shared_input_pin,
    input wire logic ref_clk_32k,
    output logic [1:0] overflow_service_request,
    output logic wake_up
);
    import dtc_pkg::*;

    // ****************************************
    // write channel
    // ****************************************
    logic aw_full_q;
    logic w_full_q;
    logic [IDX_W-1:0] wr_idx_q;
    logic [7:0] wr_byte_q;
    logic wr_lane_q;
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic wr_fire;
    logic wr_mapped;

    assign wr_fire = aw_full_q & w_full_q & ~bvalid_q;

    always_comb begin
        case (wr_idx_q)
            IDX_COUNT0_HIGH_BYTE, IDX_COUNT0_LOW_BYTE, IDX_COUNT0_CONTROL,
            IDX_COUNT1_HIGH_BYTE, IDX_COUNT1_LOW_BYTE, IDX_COUNT1_CONTROL,
            IDX_OVERFLOW_STATUS: wr_mapped = 1'b1;
            default: wr_mapped = 1'b0;
        endcase
    end

    // address and data are taken in either order; each is held until the write fires
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            wr_idx_q <= '0;
            wr_byte_q <= '0;
            wr_lane_q <= 1'b0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && awready_q) begin
                aw_full_q <= 1'b1;
                awready_q <= 1'b0;
                wr_idx_q <= s_axi_awaddr[ADDR_W-1:2];
            end
            if (s_axi_wvalid && wready_q) begin
                w_full_q <= 1'b1;
                wready_q <= 1'b0;
                wr_byte_q <= s_axi_wdata[7:0];
                wr_lane_q <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end
            if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
                awready_q <= 1'b1;
                wready_q <= 1'b1;
            end
        end
    end

    // registers change only when the low byte lane is strobed
    logic wr_en;
    assign wr_en = wr_fire & wr_lane_q;

    // ****************************************
    // read channel
    // ****************************************
    logic arready_q;
    logic rvalid_q;
    logic [DATA_W-1:0] rdata_q;
    logic [1:0] rresp_q;
    logic rd_fire;
    logic [IDX_W-1:0] rd_idx;
    logic [7:0] rd_byte;
    logic rd_mapped;

    assign rd_fire = s_axi_arvalid & arready_q;
    assign rd_idx = s_axi_araddr[ADDR_W-1:2];

    // per-counter state, one element per counter
    logic [15:0] count_q [2];
    logic [15:0] preload_q [2];
    logic [7:0] lowbuf_q [2];
    logic [1:0] mode_q [2];
    logic run_q [2];
    logic edge_q [2];
    logic [1:0] flag_q;
    logic [1:0] enable_q;
    logic [1:0] ovf;

    function automatic logic [7:0] ctl_image(input logic [1:0] mode, input logic run,
                                             input logic edge_sel);
        logic [7:0] v;
        v = 8'h00; // R7
        v[CTL_MODE_HI:CTL_MODE_LO] = mode;
        v[CTL_RUN_BIT] = run;
        v[CTL_EDGE_BIT] = edge_sel; // R23
        return v;
    endfunction : ctl_image

    always_comb begin
        rd_byte = 8'h00;
        rd_mapped = 1'b1;
        case (rd_idx)
            IDX_COUNT0_HIGH_BYTE: rd_byte = count_q[0][15:8];
            IDX_COUNT0_LOW_BYTE: rd_byte = lowbuf_q[0]; // R6
            IDX_COUNT0_CONTROL: rd_byte = ctl_image(mode_q[0], run_q[0], edge_q[0]);
            IDX_COUNT1_HIGH_BYTE: rd_byte = count_q[1][15:8];
            IDX_COUNT1_LOW_BYTE: rd_byte = lowbuf_q[1]; // R6
            IDX_COUNT1_CONTROL: rd_byte = ctl_image(mode_q[1], run_q[1], edge_q[1]);
            IDX_OVERFLOW_STATUS: begin
                rd_byte[ST_FLAG_LO +: 2] = flag_q;
                rd_byte[ST_EN_LO +: 2] = enable_q;
            end
            default: rd_mapped = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end else begin
            if (rd_fire) begin
                arready_q <= 1'b0;
                rvalid_q <= 1'b1;
                rdata_q <= {24'h000000, rd_byte};
                rresp_q <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
            end
            if (rvalid_q && s_axi_rready) begin
                rvalid_q <= 1'b0;
                arready_q <= 1'b1;
            end
        end
    end

    // ****************************************
    // clock sources and pin synchronisers
    // ****************************************
    logic [PRESCALE_W-1:0] prescale_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prescale_q <= '0;
        end else begin
            prescale_q <= prescale_q + 1'b1; // R1
        end
    end

    // inputs: [0] counter zero pin, [1] counter one pin, [2] reference clock
    logic [2:0] in_raw;
    logic [2:0] in_meta_q;
    logic [2:0] in_sync_q;
    logic [2:0] in_prev_q;

    assign in_raw = {ref_clk_32k, counter_one_shared_input_pin, counter_zero_input_pin};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            in_meta_q <= '0;
            in_sync_q <= '0;
            in_prev_q <= '0;
        end else begin
            in_meta_q <= in_raw;
            in_sync_q <= in_meta_q;
            in_prev_q <= in_sync_q;
        end
    end

    // internal source level: instruction clock for zero, reference for one
    logic [1:0] src_lvl;
    logic [1:0] src_prev_q;

    assign src_lvl[0] = prescale_q[PRESCALE_W-1]; // R1
    assign src_lvl[1] = in_sync_q[2]; // R2

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            src_prev_q <= '0;
        end else begin
            src_prev_q <= src_lvl;
        end
    end

    // ****************************************
    // counters
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_ctr
            localparam logic [IDX_W-1:0] IDX_HI = (gi == 0) ? IDX_COUNT0_HIGH_BYTE
                                                            : IDX_COUNT1_HIGH_BYTE;
            localparam logic [IDX_W-1:0] IDX_LO = (gi == 0) ? IDX_COUNT0_LOW_BYTE
                                                            : IDX_COUNT1_LOW_BYTE;
            localparam logic [IDX_W-1:0] IDX_CT = (gi == 0) ? IDX_COUNT0_CONTROL
                                                            : IDX_COUNT1_CONTROL;
            logic pin_rise;
            logic pin_fall;
            logic src_rise;
            logic src_fall;
            logic sel_pin_edge;
            logic sel_src_edge;
            logic pw_active_q;
            logic pw_start;
            logic pw_stop;
            logic tick;
            logic wr_hi;
            logic wr_lo;
            logic wr_ct;
            logic [15:0] new_preload;

            assign pin_rise = in_sync_q[gi] & ~in_prev_q[gi];
            assign pin_fall = ~in_sync_q[gi] & in_prev_q[gi];
            assign src_rise = src_lvl[gi] & ~src_prev_q[gi];
            assign src_fall = ~src_lvl[gi] & src_prev_q[gi];
            assign sel_pin_edge = edge_q[gi] ? pin_fall : pin_rise; // R10
            assign sel_src_edge = edge_q[gi] ? src_fall : src_rise; // R10

            assign wr_hi = wr_en & (wr_idx_q == IDX_HI);
            assign wr_lo = wr_en & (wr_idx_q == IDX_LO);
            assign wr_ct = wr_en & (wr_idx_q == IDX_CT);
            assign new_preload = {wr_byte_q, lowbuf_q[gi]}; // R5

            // pulse mode: edge bit 1 measures high level, 0 measures low level
            assign pw_start = (mode_q[gi] == DTC_MODE_PULSE) & run_q[gi] & ~pw_active_q
                              & (edge_q[gi] ? pin_rise : pin_fall); // R14 R16
            assign pw_stop = pw_active_q & (edge_q[gi] ? pin_fall : pin_rise); // R14

            always_comb begin
                tick = 1'b0;
                if (run_q[gi]) begin // R8
                    case (mode_q[gi]) // R9
                        DTC_MODE_EVENT: tick = sel_pin_edge; // R11
                        DTC_MODE_TIMER: tick = sel_src_edge; // R3
                        DTC_MODE_PULSE: tick = pw_active_q & ~pw_stop & src_rise; // R12
                        default: tick = 1'b0;
                    endcase
                end
            end

            assign ovf[gi] = tick & (count_q[gi] == COUNT_MAX);

            // write of the low byte wins over a high-byte read landing in the same cycle
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    lowbuf_q[gi] <= '0;
                end else if (wr_lo) begin
                    lowbuf_q[gi] <= wr_byte_q; // R4
                end else if (rd_fire && rd_idx == IDX_HI) begin
                    lowbuf_q[gi] <= count_q[gi][7:0]; // R6
                end
            end

            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    preload_q[gi] <= '0;
                end else if (wr_hi) begin
                    preload_q[gi] <= new_preload; // R5 R22
                end
            end

            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    count_q[gi] <= '0;
                end else if (wr_hi && !run_q[gi]) begin
                    count_q[gi] <= new_preload; // R21
                end else if (ovf[gi]) begin
                    count_q[gi] <= preload_q[gi]; // R13 R17
                end else if (tick) begin
                    count_q[gi] <= count_q[gi] + 16'h0001; // R3
                end
            end

            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    mode_q[gi] <= DTC_MODE_UNUSED;
                    edge_q[gi] <= 1'b0;
                end else if (wr_ct) begin
                    mode_q[gi] <= wr_byte_q[CTL_MODE_HI:CTL_MODE_LO]; // R9
                    edge_q[gi] <= wr_byte_q[CTL_EDGE_BIT]; // R23
                end
            end

            // a software set of run beats the end-of-pulse clear in the same cycle
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    run_q[gi] <= 1'b0;
                end else if (wr_ct) begin
                    run_q[gi] <= wr_byte_q[CTL_RUN_BIT]; // R8 R18
                end else if (pw_stop) begin
                    run_q[gi] <= 1'b0; // R14 R15
                end
            end

            // the measurement stays armed only while run is set in pulse mode
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    pw_active_q <= 1'b0;
                end else if (!run_q[gi] || mode_q[gi] != DTC_MODE_PULSE) begin
                    pw_active_q <= 1'b0;
                end else if (pw_stop) begin
                    pw_active_q <= 1'b0; // R15
                end else if (pw_start) begin
                    pw_active_q <= 1'b1; // R16
                end
            end
        end
    endgenerate

    // ****************************************
    // overflow flags, enables and outputs
    // ****************************************
    logic [1:0] flag_clr;
    logic st_wr;

    assign st_wr = wr_en & (wr_idx_q == IDX_OVERFLOW_STATUS);
    assign flag_clr = st_wr ? wr_byte_q[ST_FLAG_LO +: 2] : 2'b00;

    // overflow in the clearing cycle keeps the flag set
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag_q <= 2'b00;
        end else begin
            flag_q <= (flag_q & ~flag_clr) | ovf; // R13
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            enable_q <= 2'b00;
        end else if (st_wr) begin
            enable_q <= wr_byte_q[ST_EN_LO +: 2];
        end
    end

    logic [1:0] service_q;
    logic wake_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            service_q <= 2'b00;
            wake_q <= 1'b0;
        end else begin
            service_q <= flag_q & enable_q; // R20
            wake_q <= |ovf; // R19
        end
    end

    assign overflow_service_request = service_q;
    assign wake_up = wake_q;
    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

endmodule : dtc_top

// >>> tb/dtc_assertions.sv
// concurrent checks on the bus handshakes and wake output of the counter block
`timescale 1ns/1ns
module dtc_assertions (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [dtc_pkg::DATA_W-1:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic wake_up
);
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // ****************************************
    // write path
    // ****************************************
    a_b_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer late or early");
    a_b_release: assert property (s_axi_bvalid && s_axi_bready
        |=> !s_axi_bvalid && s_axi_awready && s_axi_wready) else $error("write not closed");
    a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while answer pending");

    // ****************************************
    // read path
    // ****************************************
    a_r_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer missing");
    a_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
        else $error("read not closed");
    a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while answer pending");
    a_rd_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");

    // ****************************************
    // wake output
    // ****************************************
    a_wake_pulse: assert property (wake_up |=> !wake_up)
        else $error("wake longer than one cycle");
endmodule : dtc_assertions

bind dtc_top dtc_assertions u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .wake_up);

// >>> tb/dtc_pin_model.sv
// event sources and reference clock seen at the counter input pins
`timescale 1ns/1ns
module dtc_pin_model (
    input wire logic aclk,
    output logic pin0,
    output logic pin1,
    output logic ref_clk
);
    // ****************************************
    // free-running reference, about 32768 Hz
    // ****************************************
    initial begin
        pin0 = 1'b0;
        pin1 = 1'b0;
        ref_clk = 1'b0;
        forever #15259 ref_clk = ~ref_clk;
    end

    // pins are async to the block, changed just after an edge anyway
    task automatic drive(input int ch, input logic lvl);
        @(posedge aclk);
        if (ch == 1) pin1 <= lvl;
        else pin0 <= lvl;
    endtask : drive

    // high for w+1 cycles, then low long enough to pass the synchroniser
    task automatic pulse(input int ch, input int w);
        drive(ch, 1'b1);
        repeat (w) @(posedge aclk);
        drive(ch, 1'b0);
        repeat (12) @(posedge aclk);
    endtask : pulse
endmodule : dtc_pin_model

// >>> tb/tb_top.sv
// self-checking bench for the dual timer/event counter
`timescale 1ns/1ns
module tb_top;
    import dtc_pkg::*;
    localparam logic [5:0] H0 = IDX_COUNT0_HIGH_BYTE;
    localparam logic [5:0] L0 = IDX_COUNT0_LOW_BYTE;
    localparam logic [5:0] C0 = IDX_COUNT0_CONTROL;
    localparam logic [5:0] H1 = IDX_COUNT1_HIGH_BYTE;
    localparam logic [5:0] C1 = IDX_COUNT1_CONTROL;
    localparam logic [5:0] ST = IDX_OVERFLOW_STATUS;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, pin0, pin1, ref_clk, wake;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [DATA_W-1:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, svc;
    logic [15:0] c, v;
    int fails, n_compared, cyc, n;

    dtc_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .counter_zero_input_pin(pin0),
        .counter_one_shared_input_pin(pin1), .ref_clk_32k(ref_clk),
        .overflow_service_request(svc), .wake_up(wake));
    dtc_pin_model u_pins (.aclk(aclk), .pin0(pin0), .pin1(pin1), .ref_clk(ref_clk));

    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    // ****************************************
    // checks and bus tasks
    // ****************************************
    task automatic chk_d(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_d

    task automatic chk_r(input logic [1:0] got, input logic [1:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("mismatch t=%0t resp got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_r

    function automatic logic [1:0] exp_resp(input logic [5:0] idx);
        return (idx < H0 || idx > ST) ? RESP_SLVERR : RESP_OKAY;
    endfunction : exp_resp

    task automatic wr(input logic [5:0] idx, input logic [7:0] b);
        awaddr <= {idx, 2'b00};
        wdata <= {24'h000000, b};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        chk_r(bresp, exp_resp(idx));
        bready <= 1'b0;
        @(posedge aclk);
    endtask : wr

    task automatic rd(input logic [5:0] idx, output logic [31:0] q);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        q = rdata;
        chk_r(rresp, exp_resp(idx));
        rready <= 1'b0;
        @(posedge aclk);
    endtask : rd

    task automatic rdk(input logic [5:0] idx, input logic [7:0] e);
        logic [31:0] t;
        rd(idx, t);
        chk_d(t, {24'h000000, e});
    endtask : rdk

    // high byte first so the low byte comes from the latch
    task automatic rdc(input logic [5:0] hi, output logic [15:0] q);
        logic [31:0] t;
        rd(hi, t);
        q[15:8] = t[7:0];
        rd(hi + 6'h01, t);
        q[7:0] = t[7:0];
    endtask : rdc

    task automatic ld(input logic [5:0] hi, input logic [15:0] val);
        wr(hi + 6'h01, val[7:0]);
        wr(hi, val[15:8]);
    endtask : ld

    // bounded so a dead counter cannot hang the run
    task automatic wait_wake(output int k);
        k = 0;
        do begin
            @(posedge aclk);
            k++;
        end while (!wake && k < 4000);
    endtask : wait_wake

    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : wrap_up

    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            wrap_up();
        end
    end

    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h00000000;
        wstrb = 4'hF;
        {fails, n_compared, cyc} = {32'h0, 32'h0, 32'h0};
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rdk(C0, 8'h00);
        rdk(C1, 8'h00);
        rdk(ST, 8'h00);
        rdk(6'h20, 8'h00);
        wr(6'h20, 8'h55);
        wr(C0, 8'hFF);
        rdk(C0, 8'hD8);
        wr(C0, 8'h00);
        ld(H0, 16'h1234);
        rdk(H0, 8'h12);
        rdk(L0, 8'h34);
        wr(L0, 8'h99);
        rdk(H0, 8'h12);
        rdk(L0, 8'h34);
        // timer on counter 0, four ticks per overflow
        ld(H0, 16'hFFFC);
        wr(ST, 8'h04);
        wr(C0, 8'h90);
        wait_wake(n);
        wait_wake(n);
        chk_d(n, 32'h10);
        chk_d({30'h0, svc}, 32'h1);
        rdk(ST, 8'h05);
        rdk(C0, 8'h90);
        ld(H0, 16'hFFF0);
        wait_wake(n);
        wait_wake(n);
        chk_d(n, 32'h40);
        wr(ST, 8'h01);
        wait_wake(n);
        chk_d({30'h0, svc}, 32'h0);
        wr(C0, 8'h00);
        wr(ST, 8'h01);
        // timer on counter 1, one overflow per reference period
        ld(H1, 16'hFFFF);
        wr(ST, 8'h08);
        wr(C1, 8'h98);
        wait_wake(n);
        wait_wake(n);
        chk_d({31'h0, (n >= 1524 && n <= 1528)}, 32'h1);
        chk_d({30'h0, svc}, 32'h2);
        wr(C1, 8'h00);
        wr(ST, 8'h02);
        // event counting on the shared pin, both edges selections
        ld(H1, 16'h0000);
        wr(C1, 8'h50);
        u_pins.drive(1, 1'b1);
        repeat (10) @(posedge aclk);
        rdc(H1, c);
        chk_d({16'h0, c}, 32'h1);
        u_pins.drive(1, 1'b0);
        repeat (10) @(posedge aclk);
        rdc(H1, c);
        chk_d({16'h0, c}, 32'h1);
        wr(C1, 8'h58);
        u_pins.pulse(1, 8);
        rdc(H1, c);
        chk_d({16'h0, c}, 32'h2);
        wr(C1, 8'h10);
        u_pins.pulse(1, 8);
        rdc(H1, c);
        chk_d({16'h0, c}, 32'h2);
        // a write without the low lane strobed must leave the register alone
        wstrb <= 4'hE;
        wr(C1, 8'h00);
        wstrb <= 4'hF;
        rdk(C1, 8'h10);
        // pulse width on counter 0 with an overflow inside the pulse
        ld(H0, 16'hFFF8);
        u_pins.drive(0, 1'b1);
        repeat (8) @(posedge aclk);
        wr(C0, 8'hD8);
        repeat (20) @(posedge aclk);
        rdc(H0, c);
        chk_d({16'h0, c}, 32'hFFF8);
        u_pins.drive(0, 1'b0);
        repeat (12) @(posedge aclk);
        u_pins.pulse(0, 40);
        rdk(C0, 8'hC8);
        rdk(ST, 8'h01);
        rdc(H0, v);
        chk_d({31'h0, (v >= 16'hFFF8 && v <= 16'hFFFB)}, 32'h1);
        u_pins.pulse(0, 40);
        rdc(H0, c);
        chk_d({16'h0, c}, {16'h0, v});
        wr(C0, 8'hD8);
        u_pins.pulse(0, 40);
        rdc(H0, c);
        chk_d({31'h0, (c !== v)}, 32'h1);
        // low-level measurement: starts on the falling edge, stops on the rise
        wr(C0, 8'hD0);
        u_pins.pulse(0, 40);
        u_pins.drive(0, 1'b1);
        repeat (6) @(posedge aclk);
        rdk(C0, 8'hC0);
        rdc(H0, v);
        chk_d({31'h0, (v !== c)}, 32'h1);
        wrap_up();
    end
endmodule : tb_top
